/* File: shared/core_exec_defines.svh */
// Offsets, field positions, reset values and timing counts of the execution core.
`ifndef CORE_EXEC_DEFINES_SVH
`define CORE_EXEC_DEFINES_SVH

// ****************************************
// Register port offsets
// ****************************************
`define OFS_FILE_LAST 8'h7f
`define OFS_WORK      8'h80
`define OFS_STATUS    8'h81
`define OFS_INTCTL    8'h82
`define OFS_PC_LO     8'h83
`define OFS_PC_HI     8'h84
`define OFS_CTRL      8'h85

// ****************************************
// Field positions
// ****************************************
`define STATUS_C   0
`define STATUS_Z   2
`define STATUS_PD  3
`define STATUS_TO  4
`define INTCTL_GIE 7
`define CTRL_WAKE  0

// ****************************************
// Reset values
// ****************************************
`define RST_WORK 8'h00
`define RST_PC   13'h0000
`define RST_FLAGS 4'hc

// ****************************************
// Timing counts in instruction cycles
// ****************************************
`define CYC_SINGLE 1
`define CYC_DOUBLE 2

`endif

/* File: shared/core_exec_pkg.sv */
// Types shared by the instruction execution core.
package core_exec_pkg;

  typedef enum logic [3:0] {
    OP_OTHER, OP_NOP, OP_INC, OP_INCSZ, OP_IORL, OP_IORF, OP_COPY_FILE,
    OP_STORE_WORK_TO_FILE, OP_LOAD_LITERAL_WORK, OP_IRQ_RETURN, OP_RETURN_WITH_LITERAL, OP_RET, OP_RLF, OP_RRF,
    OP_SLEEP
  } op_e;

  typedef enum logic [1:0] {ST_RUN, ST_SKIP, ST_POP, ST_SLEEP} state_e;

  typedef struct packed {
    logic timeout_flag;
    logic powerdown_flag;
    logic z;
    logic c;
  } flags_s;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } bus_s;

endpackage : core_exec_pkg

/* File: hdl/core_exec.sv */
// Execution core for a subset of the 14-bit instruction set.
//
// Design decisions made here: the strobed register port and the address map.
`timescale 1ns/1ps
`include "core_exec_defines.svh"

module core_exec (
  // Clock and reset
  input  wire logic                  clk,
  input  wire logic                  rst_n,
  // Instruction words from program memory
  input  wire logic [13:0]           instr,
  input  wire logic                  instr_valid,
  output logic                       instr_ready,
  // Return address push from the call logic
  input  wire logic                  push_valid,
  input  wire logic [12:0]           push_addr,
  // Register port
  input  wire core_exec_pkg::bus_s   bus,
  output logic [7:0]                 rdata,
  // Core state
  output logic [12:0]                pc,
  output logic [7:0]                 w,
  output core_exec_pkg::flags_s      flags,
  output logic                       global_irq_allow,
  output logic                       wdt_clear,
  output logic                       asleep
);

  // ****************************************
  // Decode
  // ****************************************
  function automatic core_exec_pkg::op_e decode(input logic [13:0] iw);
    core_exec_pkg::op_e op;
    op = core_exec_pkg::OP_OTHER;
    if (iw == 14'h0009) begin
      op = core_exec_pkg::OP_IRQ_RETURN;
    end else if (iw == 14'h0008) begin
      op = core_exec_pkg::OP_RET;
    end else if (iw == 14'h0063) begin
      op = core_exec_pkg::OP_SLEEP;
    end else if (iw[13:7] == 7'h01) begin
      op = core_exec_pkg::OP_STORE_WORK_TO_FILE;
    end else if (iw[13:7] == 7'h00 && iw[4:0] == 5'h00) begin
      op = core_exec_pkg::OP_NOP;
    end else if (iw[13:12] == 2'h0) begin
      case (iw[11:8])
        4'ha:    op = core_exec_pkg::OP_INC;
        4'hf:    op = core_exec_pkg::OP_INCSZ;
        4'h4:    op = core_exec_pkg::OP_IORF;
        4'h8:    op = core_exec_pkg::OP_COPY_FILE;
        4'hd:    op = core_exec_pkg::OP_RLF;
        4'hc:    op = core_exec_pkg::OP_RRF;
        default: op = core_exec_pkg::OP_OTHER;
      endcase
    end else if (iw[13:12] == 2'h3) begin
      if (iw[11:8] == 4'h8) begin
        op = core_exec_pkg::OP_IORL;
      end else if (iw[11:10] == 2'h0) begin
        op = core_exec_pkg::OP_LOAD_LITERAL_WORK;
      end else if (iw[11:10] == 2'h1) begin
        op = core_exec_pkg::OP_RETURN_WITH_LITERAL;
      end
    end
    return op;
  endfunction : decode

  // ****************************************
  // State
  // ****************************************
  core_exec_pkg::state_e state;
  core_exec_pkg::state_e next_state;
  core_exec_pkg::flags_s next_flags;
  core_exec_pkg::op_e    op;
  logic [7:0]  file_reg [0:127];
  logic [12:0] stack [0:7];
  logic [2:0]  sp;
  logic [2:0]  next_sp;
  logic [12:0] next_pc;
  logic [12:0] stack_top_entry;
  logic [7:0]  next_w;
  logic [7:0]  next_rdata;
  logic [7:0]  fv;
  logic [7:0]  k;
  logic [7:0]  res;
  logic [7:0]  f_wd;
  logic [6:0]  f_wa;
  logic        f_we;
  logic        push_we;
  logic        res_ok;
  logic        next_gie;
  logic        next_wdt;
  logic        dir;
  logic        take;
  logic        exec;

  assign op          = decode(instr);
  assign k           = instr[7:0];
  assign dir         = instr[7];
  assign fv          = file_reg[instr[6:0]];
  assign stack_top_entry         = stack[sp - 3'h1];
  assign asleep      = (state == core_exec_pkg::ST_SLEEP);
  assign instr_ready = !asleep;
  assign take        = instr_valid && instr_ready;
  assign exec        = take && state == core_exec_pkg::ST_RUN;

  // ****************************************
  // Next-state logic
  // ****************************************
  always_comb begin
    next_state = state;
    next_flags = flags;
    next_pc    = pc;
    next_w     = w;
    next_sp    = sp;
    next_gie   = global_irq_allow;
    next_wdt   = 1'b0;
    res        = 8'h00;
    res_ok     = 1'b0;
    f_we       = 1'b0;
    f_wa       = bus.addr[6:0];
    f_wd       = bus.wdata;
    push_we    = 1'b0;
    // Software writes go first so that an instruction in the same cycle wins.
    if (bus.wr) begin
      case (bus.addr)
        `OFS_WORK:   next_w = bus.wdata;
        `OFS_STATUS: begin
          next_flags.c              = bus.wdata[`STATUS_C];
          next_flags.z              = bus.wdata[`STATUS_Z];
          next_flags.powerdown_flag = bus.wdata[`STATUS_PD];
          next_flags.timeout_flag   = bus.wdata[`STATUS_TO];
        end
        `OFS_INTCTL: next_gie = bus.wdata[`INTCTL_GIE];
        `OFS_CTRL: begin
          if (bus.wdata[`CTRL_WAKE] && asleep) begin
            next_state = core_exec_pkg::ST_RUN;
          end
        end
        default: f_we = !bus.addr[7];
      endcase
    end
    if (exec) begin
      next_pc = pc + 13'h0001;
      case (op)
        core_exec_pkg::OP_INC: begin
          res          = fv + 8'h01;
          res_ok       = 1'b1;
          next_flags.z = (res == 8'h00);
        end
        core_exec_pkg::OP_INCSZ: begin
          res    = fv + 8'h01;
          res_ok = 1'b1;
          if (res == 8'h00) begin
            next_state = core_exec_pkg::ST_SKIP;
          end
        end
        core_exec_pkg::OP_IORL: begin
          next_w       = w | k;
          next_flags.z = ((w | k) == 8'h00);
        end
        core_exec_pkg::OP_IORF: begin
          res          = w | fv;
          res_ok       = 1'b1;
          next_flags.z = (res == 8'h00);
        end
        core_exec_pkg::OP_COPY_FILE: begin
          res          = fv;
          res_ok       = 1'b1;
          next_flags.z = (fv == 8'h00);
        end
        core_exec_pkg::OP_STORE_WORK_TO_FILE: begin
          f_we = 1'b1;
          f_wa = instr[6:0];
          f_wd = w;
        end
        core_exec_pkg::OP_LOAD_LITERAL_WORK: next_w = k;
        core_exec_pkg::OP_IRQ_RETURN: begin
          next_pc    = stack_top_entry;
          next_sp    = sp - 3'h1;
          next_gie   = 1'b1;
          next_state = core_exec_pkg::ST_POP;
        end
        core_exec_pkg::OP_RETURN_WITH_LITERAL: begin
          next_w     = k;
          next_pc    = stack_top_entry;
          next_sp    = sp - 3'h1;
          next_state = core_exec_pkg::ST_POP;
        end
        core_exec_pkg::OP_RET: begin
          next_pc    = stack_top_entry;
          next_sp    = sp - 3'h1;
          next_state = core_exec_pkg::ST_POP;
        end
        core_exec_pkg::OP_RLF: begin
          res          = {fv[6:0], flags.c};
          res_ok       = 1'b1;
          next_flags.c = fv[7];
        end
        core_exec_pkg::OP_RRF: begin
          res          = {flags.c, fv[7:1]};
          res_ok       = 1'b1;
          next_flags.c = fv[0];
        end
        core_exec_pkg::OP_SLEEP: begin
          next_wdt                  = 1'b1;
          next_flags.timeout_flag   = 1'b1;
          next_flags.powerdown_flag = 1'b0;
          next_state                = core_exec_pkg::ST_SLEEP;
        end
        default: ;
      endcase
      if (res_ok) begin
        if (dir) begin
          f_we = 1'b1;
          f_wa = instr[6:0];
          f_wd = res;
        end else begin
          next_w = res;
        end
      end
    end else if (take) begin
      // The prefetched word is dropped; a skip still steps past it.
      if (state == core_exec_pkg::ST_SKIP) begin
        next_pc = pc + 13'h0001;
      end
      next_state = core_exec_pkg::ST_RUN;
    end
    // A push meeting a pop is dropped; the call logic never issues both.
    if (push_valid && next_sp == sp) begin
      push_we = 1'b1;
      next_sp = sp + 3'h1;
    end
    next_rdata = 8'h00;
    if (bus.rd) begin
      case (bus.addr)
        `OFS_WORK:   next_rdata = w;
        `OFS_STATUS: next_rdata = {3'h0, flags.timeout_flag, flags.powerdown_flag,
                                   flags.z, 1'b0, flags.c};
        `OFS_INTCTL: next_rdata = {global_irq_allow, 7'h00};
        `OFS_PC_LO:  next_rdata = pc[7:0];
        `OFS_PC_HI:  next_rdata = {3'h0, pc[12:8]};
        `OFS_CTRL:   next_rdata = {7'h00, asleep};
        default:     next_rdata = bus.addr[7] ? 8'h00 : file_reg[bus.addr[6:0]];
      endcase
    end
  end

  // ****************************************
  // Registers
  // ****************************************
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state            <= core_exec_pkg::ST_RUN;
      flags            <= `RST_FLAGS;
      pc               <= `RST_PC;
      w                <= `RST_WORK;
      sp               <= 3'h0;
      global_irq_allow <= 1'b0;
      wdt_clear        <= 1'b0;
      rdata            <= 8'h00;
    end else begin
      state            <= next_state;
      flags            <= next_flags;
      pc               <= next_pc;
      w                <= next_w;
      sp               <= next_sp;
      global_irq_allow <= next_gie;
      wdt_clear        <= next_wdt;
      rdata            <= next_rdata;
    end
  end

  // Storage has no reset; software is expected to initialise what it uses.
  always_ff @(posedge clk) begin
    if (f_we) begin
      file_reg[f_wa] <= f_wd;
    end
    if (push_we) begin
      stack[sp] <= push_addr;
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  logic quiet;
  assign quiet = exec && !bus.wr;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence s_flush;
    state != core_exec_pkg::ST_RUN ##1 state == core_exec_pkg::ST_RUN;
  endsequence

  property p_inc;
    quiet && op == core_exec_pkg::OP_INC
      |=> flags.z == ($past(fv) == 8'hff)
          && ($past(dir) ? w == $past(w) : w == 8'($past(fv) + 8'h01));
  endproperty
  a_inc: assert property (p_inc) else $error("increment result wrong");

  property p_skip;
    quiet && op == core_exec_pkg::OP_INCSZ && fv == 8'hff && !push_valid
      ##1 instr_valid |-> s_flush and $stable(flags);
  endproperty
  a_skip: assert property (p_skip) else $error("skip not two cycles");

  property p_noskip;
    quiet && op == core_exec_pkg::OP_INCSZ && fv != 8'hff
      |=> state == core_exec_pkg::ST_RUN;
  endproperty
  a_noskip: assert property (p_noskip) else $error("spurious skip");

  property p_iorl;
    quiet && op == core_exec_pkg::OP_IORL |=> w == ($past(w) | $past(k));
  endproperty
  a_iorl: assert property (p_iorl) else $error("literal OR wrong");

  property p_load_literal_work;
    quiet && op == core_exec_pkg::OP_LOAD_LITERAL_WORK |=> w == $past(k) && $stable(flags);
  endproperty
  a_load_literal_work: assert property (p_load_literal_work) else $error("literal load wrong");

  property p_irq_return;
    quiet && op == core_exec_pkg::OP_IRQ_RETURN
      |=> global_irq_allow && pc == $past(stack_top_entry) && sp == $past(sp) - 3'h1;
  endproperty
  a_irq_return: assert property (p_irq_return) else $error("irq return wrong");

  property p_ret;
    quiet && op == core_exec_pkg::OP_RET |=> pc == $past(stack_top_entry) && $stable(w);
  endproperty
  a_ret: assert property (p_ret) else $error("return wrong");

  property p_rlf;
    quiet && op == core_exec_pkg::OP_RLF
      |=> flags.c == $past(fv[7])
          && ($past(dir) ? w == $past(w) : w == {$past(fv[6:0]), $past(flags.c)});
  endproperty
  a_rlf: assert property (p_rlf) else $error("rotate left wrong");

  property p_sleep;
    exec && op == core_exec_pkg::OP_SLEEP
      |=> wdt_clear && asleep && flags.timeout_flag && !flags.powerdown_flag;
  endproperty
  a_sleep: assert property (p_sleep) else $error("sleep entry wrong");

endmodule : core_exec

/* File: test/prog_mem.sv */
// Program memory model that offers the word at the current fetch address.
`timescale 1ns/1ps

module prog_mem (
  // Fetch side
  input  wire logic [12:0] pc,
  input  wire logic        enable,
  // Word side
  output logic      [13:0] instr,
  output logic             instr_valid
);
  logic [13:0] rom [0:31];

  // While idle the word lines show the inverted word, so a stale opcode cannot pass for a fresh one.
  assign instr_valid = enable;
  assign instr       = enable ? rom[pc[4:0]] : ~rom[pc[4:0]];
endmodule : prog_mem

/* File: test/core_instruction_exec_subset_test.sv */
// Self-checking bench for the instruction execution core.
`timescale 1ns/1ps
`include "core_exec_defines.svh"

module core_instruction_exec_subset_test;
  logic                  clk;
  logic                  rst_n;
  logic                  run;
  logic                  push_valid;
  logic [12:0]           push_addr;
  core_exec_pkg::bus_s   bus;
  logic [7:0]            rdata;
  logic [12:0]           pc;
  logic [7:0]            w;
  core_exec_pkg::flags_s flags;
  logic                  global_irq_allow;
  logic                  wdt_clear;
  logic                  asleep;
  logic [13:0]           instr;
  logic                  instr_valid;
  logic                  instr_ready;
  logic [7:0]            got;
  int                    n_errors;
  int                    samples_checked;
  int                    n_taken;
  int                    n_wdt;
  logic [13:0]           prog [0:13] = '{14'h305a, 14'h3881, 14'h0090, 14'h0a91, 14'h0f12,
    14'h0097, 14'h0d94, 14'h0c15, 14'h0493, 14'h0891, 14'h0f96, 14'h0098, 14'h343c, 14'h0000};
  logic [7:0]            pre [0:8] = '{8'h00, 8'hff, 8'hff, 8'h00, 8'h80,
    8'h02, 8'h05, 8'h33, 8'h00};
  logic [7:0]            exp [0:8] = '{8'hdb, 8'h00, 8'hff, 8'h81, 8'h00,
    8'h02, 8'h06, 8'h33, 8'h81};

  core_exec dut (
    .clk(clk), .rst_n(rst_n), .instr(instr), .instr_valid(instr_valid),
    .instr_ready(instr_ready), .push_valid(push_valid), .push_addr(push_addr),
    .bus(bus), .rdata(rdata), .pc(pc), .w(w), .flags(flags),
    .global_irq_allow(global_irq_allow), .wdt_clear(wdt_clear), .asleep(asleep)
  );

  prog_mem mem (.pc(pc), .enable(run), .instr(instr), .instr_valid(instr_valid));

  always #2.5 clk = ~clk;

  always @(posedge clk) begin
    if (instr_valid && instr_ready === 1'b1) n_taken++;
    if (wdt_clear === 1'b1) n_wdt++;
  end

  // ****************************************
  // Access tasks
  // ****************************************
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    samples_checked++;
    if (g !== e) begin
      n_errors++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk

  task automatic bus_wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clk);
    bus <= '0;
  endtask : bus_wr

  task automatic bus_rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge clk);
    bus <= '0;
    #1;
    d = rdata;
  endtask : bus_rd

  task automatic conclude();
    if (n_errors == 0 && samples_checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : conclude

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    clk = 1'b0;
    rst_n = 1'b0;
    run = 1'b0;
    push_valid = 1'b0;
    push_addr = '0;
    bus = '0;
    n_errors = 0;
    samples_checked = 0;
    n_taken = 0;
    n_wdt = 0;
    for (int i = 0; i < 32; i++) mem.rom[i] = 14'h0000;
    for (int i = 0; i < 14; i++) mem.rom[i] = prog[i];
    mem.rom[20] = 14'h0008;
    mem.rom[21] = 14'h0009;
    mem.rom[22] = 14'h0063;
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    #1;
    chk(16'(flags), 16'h000c);
    chk(16'(global_irq_allow), 16'h0000);
    for (int i = 0; i < 9; i++) bus_wr(8'h10 + 8'(i), pre[i]);
    for (int i = 0; i < 3; i++) begin
      @(posedge clk);
      push_valid <= 1'b1;
      push_addr  <= 13'd22 - 13'(i);
      @(posedge clk);
      push_valid <= 1'b0;
    end
    @(posedge clk);
    run <= 1'b1;
    for (int i = 0; i < 100 && asleep !== 1'b1; i++) @(posedge clk);
    run <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
    chk(16'(n_taken), 16'd19);
    chk(16'(n_wdt), 16'd1);
    chk(16'(flags), 16'h000a);
    chk(16'(w), 16'h003c);
    chk(16'(global_irq_allow), 16'h0001);
    chk(16'(asleep), 16'h0001);
    for (int i = 0; i < 9; i++) begin
      bus_rd(8'h10 + 8'(i), got);
      chk(16'(got), 16'(exp[i]));
    end
    bus_rd(`OFS_WORK, got);
    chk(16'(got), 16'h003c);
    bus_rd(`OFS_STATUS, got);
    chk(16'(got & 8'h1d), 16'h0014);
    bus_rd(`OFS_INTCTL, got);
    chk(16'(got[`INTCTL_GIE]), 16'h0001);
    bus_rd(`OFS_PC_LO, got);
    chk(16'(got), 16'h0017);
    bus_rd(`OFS_PC_HI, got);
    chk(16'(got), 16'h0000);
    bus_wr(8'h90, 8'hff);
    bus_rd(8'h90, got);
    chk(16'(got), 16'h0000);
    bus_rd(`OFS_CTRL, got);
    chk(16'(got[`CTRL_WAKE]), 16'h0001);
    bus_wr(`OFS_CTRL, 8'h01);
    @(posedge clk);
    #1;
    chk(16'(asleep), 16'h0000);
    conclude();
  end

  // A hang in the wait loops would otherwise stall the run for good.
  initial begin
    #5000;
    n_errors++;
    conclude();
  end
endmodule : core_instruction_exec_subset_test
